// File: logic/adc_conversion_sequencer.sv
// Function
// - Each converter has 16 channels with own input, trigger and window.
// - Pair bit 0: channels 2k, 2k+1 run independently with own settings.
// - Pair bit 1: even control drives both, odd ignored, two results stored.
// - In a pair, even input select picks one input per multiplexer.
// - Any mix of independent channels and pairs, 16 singles to 8 pairs.
// - Eight external triggers plus two internal triggers from own first interrupts.
// - Two select words pick external or internal, and which internal interrupt.
// - External trigger field in channel control picks one of eight triggers.
// - One conversion at a time, pending channels arbitrated by priority control.
// - Two sample-and-hold units, each behind its own multiplexer.
// - Multiplexer A: six external inputs plus temperature sensor on first converter.
// - Multiplexer B: four external inputs plus low reference tied to ground.
// - Sample-and-hold units sample with the converting channel's window.
// - Sixteen result registers per converter, indexed by channel.
// - Source select maps channel completions onto eight interrupts per converter.
// - Matching interrupts of both converters are combined before delivery.

`timescale 1ns/1ps
module adc_conversion_sequencer (
  input  wire logic                    core_clk,                    // Core clock, 200 MHz.
  input  wire logic                    nrst,                        // Asynchronous reset, active low.
  input  wire logic [1:0][7:0]         ext_trigger,                 // External start triggers, unsynchronised.
  input  wire logic [1:0][15:0][15:0]  channel_conv_control,        // Per-channel control words.
  input  wire logic [1:0][7:0]         pair_mode_select,            // Pair-mode bit per channel pair.
  input  wire logic [1:0][15:0]        internal_trigger_select_lo,  // Internal source low select bit.
  input  wire logic [1:0][15:0]        internal_trigger_select_hi,  // Internal source high select bit.
  input  wire logic [1:0][4:0]         priority_control,            // Fixed-priority channel count.
  input  wire logic [1:0][7:0][4:0]    interrupt_source_select,     // Enable and channel per interrupt.
  input  wire logic [1:0][7:0]         irq_ack,                     // Clear pulses for interrupt flags.
  input  wire logic [1:0][11:0]        conv_data,                   // Converter core output data.
  output logic      [1:0][2:0]         mux_a_select,                // Multiplexer A input.
  output logic      [1:0][2:0]         mux_b_select,                // Multiplexer B input.
  output logic      [1:0]              sh_a_sample,                 // Sample-and-hold A tracking.
  output logic      [1:0]              sh_b_sample,                 // Sample-and-hold B tracking.
  output logic      [1:0]              conv_start,                  // Conversion start pulse.
  output logic      [1:0]              conv_from_b,                 // Conversion reads hold unit B.
  output logic      [1:0]              conv_busy,                   // Converter busy.
  output logic      [1:0][15:0]        pending,                     // Pending channel requests.
  output logic      [1:0][15:0][11:0]  conv_result,                 // Result registers.
  output logic      [1:0][7:0]         irq_flag,                    // Per-converter interrupt flags.
  output logic      [7:0]              conversion_done_irq          // Combined interrupts.
);
  logic rst_s1_q;
  logic rst_n;

  // Reset is released through two flops so no flop leaves reset on a ragged edge.
  // Assertion is immediate; only the release waits for the clock.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  genvar g;

  generate
    for (g = 0; g < adc_seq_pkg::NUM_CONV; g++)
    begin : conv
      // Trigger synchronisers and requests.
      logic [7:0]  ext_s1_q;
      logic [7:0]  ext_s2_q;
      logic [7:0]  ext_s3_q;
      logic [7:0]  ext_edge;
      logic [15:0] trig;
      logic [15:0] clr;

      // Arbitration and the job in flight.
      logic        gnt_valid;
      logic [3:0]  gnt_idx;
      logic [3:0]  gnt_sel;
      logic        take;
      logic        go_q;
      logic [3:0]  act_ch_q;
      logic        act_pair_q;
      logic        act_b_q;
      logic [15:0] act_ctl;

      // Capture pipeline and interrupt sources.
      logic        cap_q;
      logic        cap_slot_q;
      logic        res_wr_q;
      logic [3:0]  res_ch_q;
      logic [7:0]  irq_set;
      conv_step_if step ();

      // External triggers are pins: two flops first, then a rising-edge detect.
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          ext_s1_q <= 8'h00;
          ext_s2_q <= 8'h00;
          ext_s3_q <= 8'h00;
        end
        else
        begin
          ext_s1_q <= ext_trigger[g];
          ext_s2_q <= ext_s1_q;
          ext_s3_q <= ext_s2_q;
        end
      end

      assign ext_edge = ext_s2_q & ~ext_s3_q;

      // Per-channel trigger source; an odd channel inside a pair never requests on its own.
      for (genvar c = 0; c < adc_seq_pkg::NUM_CH; c++)
      begin : ch
        logic [1:0] src;
        logic [2:0] tsel;
        assign src  = {internal_trigger_select_hi[g][c], internal_trigger_select_lo[g][c]};
        assign tsel = channel_conv_control[g][c][adc_seq_pkg::TRIG_LSB +: adc_seq_pkg::TRIG_W];

        always_comb
        begin
          if ((c % 2 == 1) && pair_mode_select[g][c / 2])
            trig[c] = 1'b0;
          else if (src == adc_seq_pkg::ITRIG_FIRST)
            trig[c] = irq_set[0];
          else if (src == adc_seq_pkg::ITRIG_SECOND)
            trig[c] = irq_set[1];
          else
            trig[c] = ext_edge[tsel];
        end

        assign clr[c] = take && (gnt_idx == 4'(c));
      end

      // Requests wait here while the converter is busy; a new trigger beats a clear.
      // Repeats merge, so one job serves every trigger seen so far.
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          pending[g] <= 16'h0000;
        else
          pending[g] <= (pending[g] & ~clr) | trig;
      end

      // Each converter arbitrates its own queue.
      conv_arbiter arb (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .req       (pending[g]),
        .prio      (priority_control[g]),
        .take      (take),
        .gnt_valid (gnt_valid),
        .gnt_idx   (gnt_idx)
      );

      // A grant is taken only when the timer is idle and no job is being launched.
      // A capture in flight also blocks it, as the write still reads the channel.
      assign take = gnt_valid && !step.busy && !step.capture && !go_q;

      // Odd channels in a pair are never granted, so the granted word is the even one.
      assign act_ctl = channel_conv_control[g][act_ch_q];

      // Input select of the channel offered for grant.
      assign gnt_sel = channel_conv_control[g][gnt_idx][adc_seq_pkg::SEL_LSB +: adc_seq_pkg::SEL_W];

      // Latch the granted channel and steer the multiplexers for its job.
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          act_ch_q        <= 4'h0;
          act_pair_q      <= 1'b0;
          act_b_q         <= 1'b0;
          go_q            <= 1'b0;

          mux_a_select[g] <= 3'h0;
          mux_b_select[g] <= adc_seq_pkg::LOW_REF;
        end
        else
        begin
          go_q <= take;

          if (take)
          begin
            act_ch_q   <= gnt_idx;
            act_pair_q <= pair_mode_select[g][gnt_idx[3:1]];
            act_b_q    <= gnt_sel[3] && !pair_mode_select[g][gnt_idx[3:1]];

            // The temperature sensor exists only on the first converter.
            if (gnt_sel[2:0] > adc_seq_pkg::MUX_A_LAST
                || (g != 0 && gnt_sel[2:0] == adc_seq_pkg::TEMP_SENSOR))
              mux_a_select[g] <= 3'h0;
            else
              mux_a_select[g] <= gnt_sel[2:0];

            // Out-of-range B selections fall back to the grounded low reference.
            if (gnt_sel[2:0] > adc_seq_pkg::MUX_B_LAST)
              mux_b_select[g] <= adc_seq_pkg::LOW_REF;
            else
              mux_b_select[g] <= gnt_sel[2:0];
          end
        end
      end

      // The timer latches the window when go is seen.
      assign step.go     = go_q;
      assign step.window = act_ctl[adc_seq_pkg::WIN_LSB +: adc_seq_pkg::WIN_W];
      assign step.two    = act_pair_q;

      // One timer per converter sequences each job.
      conv_timer tmr (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .step     (step.tmr)
      );

      // Hold-unit and converter controls; a pair samples A and B at the same instant.
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sh_a_sample[g] <= 1'b0;
          sh_b_sample[g] <= 1'b0;
          conv_start[g]  <= 1'b0;
          conv_from_b[g] <= 1'b0;
          conv_busy[g]   <= 1'b0;

          cap_q          <= 1'b0;
          cap_slot_q     <= 1'b0;
        end
        else
        begin
          sh_a_sample[g] <= step.sample && (act_pair_q || !act_b_q);
          sh_b_sample[g] <= step.sample && (act_pair_q || act_b_q);

          conv_start[g]  <= step.start;
          if (step.start)
            conv_from_b[g] <= act_b_q || (act_pair_q && step.slot);

          conv_busy[g]   <= step.busy || go_q;
          cap_q          <= step.capture;
          cap_slot_q     <= step.slot;
        end
      end

      // Results go to the register named after the channel; the second of a pair goes odd.
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          conv_result[g] <= {adc_seq_pkg::NUM_CH{adc_seq_pkg::RST_RES}};
          res_wr_q       <= 1'b0;
          res_ch_q       <= 4'h0;
        end
        else
        begin
          res_wr_q <= cap_q;

          if (cap_q)
          begin
            res_ch_q <= {act_ch_q[3:1], act_ch_q[0] | cap_slot_q};
            conv_result[g][{act_ch_q[3:1], act_ch_q[0] | cap_slot_q}] <= conv_data[g];
          end
        end
      end

      // Each interrupt fires when its mapped channel's result has just been written.
      for (genvar k = 0; k < adc_seq_pkg::NUM_IRQ; k++)
      begin : irq
        assign irq_set[k] = res_wr_q
                            && interrupt_source_select[g][k][adc_seq_pkg::ISRC_EN]
                            && (interrupt_source_select[g][k][3:0] == res_ch_q);
      end

      // Sticky flags; a completion in the acknowledge cycle keeps the flag set.
      // Acknowledge comes from the same clock, so it is used as is.
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          irq_flag[g] <= 8'h00;
        else
          irq_flag[g] <= (irq_flag[g] & ~irq_ack[g]) | irq_set;
      end
    end

  endgenerate

  // Both converters must have flagged an interrupt before it is delivered.
  // Sticky flags let the slower converter catch up.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      conversion_done_irq <= 8'h00;
    else
      conversion_done_irq <= irq_flag[0] & irq_flag[1];
  end
endmodule : adc_conversion_sequencer

// File: logic/adc_seq_pkg.sv
package adc_seq_pkg;
  localparam int NUM_CONV = 2;
  localparam int NUM_CH   = 16;
  localparam int NUM_PAIR = 8;
  localparam int NUM_EXT  = 8;
  localparam int NUM_IRQ  = 8;
  localparam int RES_W    = 12;
  localparam int CTL_W    = 16;
  localparam int PRIO_W   = 5;
  // Channel control word layout.
  localparam int SEL_LSB  = 0;
  localparam int SEL_W    = 4;
  localparam int TRIG_LSB = 4;
  localparam int TRIG_W   = 3;
  localparam int WIN_LSB  = 7;
  localparam int WIN_W    = 9;
  // Interrupt source select word: enable bit over a channel number.
  localparam int ISRC_W   = 5;
  localparam int ISRC_EN  = 4;
  // Internal trigger codes formed as {hi bit, lo bit}.
  localparam logic [1:0] ITRIG_FIRST  = 2'h1;
  localparam logic [1:0] ITRIG_SECOND = 2'h2;
  // Multiplexer inputs.
  localparam logic [2:0] MUX_A_LAST  = 3'h6;
  localparam logic [2:0] TEMP_SENSOR = 3'h6;
  localparam logic [2:0] MUX_B_LAST  = 3'h4;
  localparam logic [2:0] LOW_REF     = 3'h4;
  // Timing.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CONV_TIME_NS  = 65;
  localparam int CONV_CYCLES   = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [15:0] RST_CTL = 16'h0000;
  localparam logic [11:0] RST_RES = 12'h000;
  typedef enum logic [1:0] {
    TMR_IDLE    = 2'b00,
    TMR_SAMPLE  = 2'b01,
    TMR_CONVERT = 2'b10
  } tmr_state_e;
endpackage : adc_seq_pkg

// File: logic/conv_step_if.sv
`timescale 1ns/1ps
interface conv_step_if;
  logic       go;      // Start one sample-and-convert job.
  logic [8:0] window;  // Sampling window field.
  logic       two;     // Two conversions follow one sample.
  logic       sample;  // Sample-and-hold tracking.
  logic       start;   // Conversion start pulse.
  logic       capture; // Result valid pulse.
  logic       slot;    // Which conversion of the job.
  logic       busy;    // Job in progress.
  modport ctl (output go, window, two, input sample, start, capture, slot, busy);
  modport tmr (input go, window, two, output sample, start, capture, slot, busy);
endinterface : conv_step_if

// File: logic/conv_arbiter.sv
`timescale 1ns/1ps
module conv_arbiter (
  input  wire logic        core_clk,   // Core clock.
  input  wire logic        rst_n,      // Synchronised reset.
  input  wire logic [15:0] req,        // Pending channels.
  input  wire logic [4:0]  prio,       // Channels below this are fixed priority.
  input  wire logic        take,       // Grant accepted this cycle.
  output logic             gnt_valid,  // Some channel granted.
  output logic [3:0]       gnt_idx     // Granted channel.
);
  logic [3:0] rr_q;
  logic [3:0] idx;
  logic       hit;

  // Fixed-priority part first, then round robin from the channel after the last winner.
  always_comb
  begin
    gnt_valid = 1'b0;
    gnt_idx   = 4'h0;
    hit       = 1'b0;
    idx       = 4'h0;
    for (int i = 0; i < 16; i++)
    begin
      if (!hit && req[i] && (5'(i) < prio))
      begin
        hit     = 1'b1;
        gnt_idx = 4'(i);
      end
    end
    for (int i = 1; i <= 16; i++)
    begin
      idx = rr_q + 4'(i);
      if (!hit && req[idx] && ({1'b0, idx} >= prio))
      begin
        hit     = 1'b1;
        gnt_idx = idx;
      end
    end
    gnt_valid = hit;
  end

  // Round-robin pointer follows every accepted grant.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rr_q <= 4'hF;
    else if (take)
      rr_q <= gnt_idx;
  end
endmodule : conv_arbiter

// File: logic/conv_timer.sv
`timescale 1ns/1ps
module conv_timer (
  input  wire logic   core_clk, // Core clock.
  input  wire logic   rst_n,    // Synchronised reset.
  conv_step_if.tmr    step      // Job handshake.
);
  adc_seq_pkg::tmr_state_e state_q;
  logic [8:0] cnt_q;

  // Window w holds the sample-and-hold for w+1 cycles, then one or two conversions run.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q      <= adc_seq_pkg::TMR_IDLE;
      cnt_q        <= 9'h000;
      step.sample  <= 1'b0;
      step.start   <= 1'b0;
      step.capture <= 1'b0;
      step.slot    <= 1'b0;
      step.busy    <= 1'b0;
    end
    else
    begin
      step.start   <= 1'b0;
      step.capture <= 1'b0;
      case (state_q)
        adc_seq_pkg::TMR_IDLE:
        begin
          if (step.go)
          begin
            state_q     <= adc_seq_pkg::TMR_SAMPLE;
            cnt_q       <= step.window;
            step.sample <= 1'b1;
            step.slot   <= 1'b0;
            step.busy   <= 1'b1;
          end
        end
        adc_seq_pkg::TMR_SAMPLE:
        begin
          if (cnt_q == 9'h000)
          begin
            state_q     <= adc_seq_pkg::TMR_CONVERT;
            cnt_q       <= 9'(adc_seq_pkg::CONV_CYCLES - 1);
            step.sample <= 1'b0;
            step.start  <= 1'b1;
            step.slot   <= step.two && !step.sample;
          end
          else
            cnt_q <= cnt_q - 9'h001;
        end
        adc_seq_pkg::TMR_CONVERT:
        begin
          // Only one conversion at a time; a pair converts its second input afterwards.
          if (cnt_q == 9'h000)
          begin
            step.capture <= 1'b1;
            if (step.two && !step.slot)
            begin
              // A short wait lets the first result be stored before the inputs switch.
              state_q <= adc_seq_pkg::TMR_SAMPLE;
              cnt_q   <= 9'h001;
            end
            else
            begin
              state_q   <= adc_seq_pkg::TMR_IDLE;
              step.busy <= 1'b0;
            end
          end
          else
            cnt_q <= cnt_q - 9'h001;
        end
        default:
        begin
          state_q   <= adc_seq_pkg::TMR_IDLE;
          step.busy <= 1'b0;
        end
      endcase
    end
  end
endmodule : conv_timer

// File: testbench/adc_seq_chk.sv
`timescale 1ns/1ps
// Timing checks on converter 0, mux range checks on both converters, and a check on the combined interrupt of both converters.
module adc_seq_chk (
  input wire logic                 core_clk,                // Core clock.
  input wire logic                 nrst,                    // Reset, active low.
  input wire logic [1:0][7:0]      pair_mode_select,        // Pair bits.
  input wire logic [1:0][7:0][4:0] interrupt_source_select, // Interrupt sources.
  input wire logic [1:0][2:0]      mux_a_select,            // Mux A input.
  input wire logic [1:0][2:0]      mux_b_select,            // Mux B input.
  input wire logic [1:0]           sh_a_sample,             // Hold A tracking.
  input wire logic [1:0]           conv_start,              // Start pulse.
  input wire logic [1:0]           conv_busy,               // Busy.
  input wire logic [1:0][15:0]     pending,                 // Pending requests.
  input wire logic [1:0][7:0]      irq_flag,                // Interrupt flags.
  input wire logic [7:0]           conversion_done_irq      // Combined interrupts.
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // Odd channel positions of every pair whose bit is set.
  function automatic logic [15:0] odd_of(input logic [7:0] p);
    logic [15:0] o;
    o = '0;
    for (int k = 0; k < 8; k++)
      o[2 * k + 1] = p[k];
    return o;
  endfunction : odd_of

  // A conversion takes many cycles, so a start can never follow another at once.
  sequence s_quiet;
    !conv_start[0] [*8];
  endsequence
  sequence s_sampled;
    sh_a_sample[0] ##1 !sh_a_sample[0];
  endsequence
  property p_start_gap;
    conv_start[0] |=> s_quiet;
  endproperty
  property p_start_busy;
    conv_start[0] |-> conv_busy[0];
  endproperty
  property p_sample_start;
    s_sampled |-> conv_start[0];
  endproperty
  property p_mux_hold;
    sh_a_sample[0] && $past(sh_a_sample[0]) |-> $stable(mux_a_select[0]);
  endproperty
  property p_mux_a;
    mux_a_select[0] <= 3'h6 && mux_a_select[1] <= 3'h5;
  endproperty
  property p_mux_b;
    mux_b_select[0] <= 3'h4 && mux_b_select[1] <= 3'h4;
  endproperty
  property p_odd;
    !(|(pending[0] & ~$past(pending[0]) & odd_of(pair_mode_select[0]) & odd_of($past(pair_mode_select[0]))));
  endproperty
  property p_served;
    pending[0] != 16'h0000 && !conv_busy[0] |-> ##[0:12] conv_busy[0];
  endproperty
  property p_irq_enabled;
    $rose(irq_flag[0][0]) |-> interrupt_source_select[0][0][4];
  endproperty
  property p_combined;
    conversion_done_irq == $past(irq_flag[0] & irq_flag[1]);
  endproperty
  a_start_gap: assert property (p_start_gap)
    else $error("start pulses too close");
  a_start_busy: assert property (p_start_busy)
    else $error("start while not busy");
  a_sample_start: assert property (p_sample_start)
    else $error("window end without start");
  a_mux_hold: assert property (p_mux_hold)
    else $error("mux moved while sampling");
  a_mux_a: assert property (p_mux_a)
    else $error("mux A out of range");
  a_mux_b: assert property (p_mux_b)
    else $error("mux B out of range");
  a_odd: assert property (p_odd)
    else $error("paired odd channel went pending");
  a_served: assert property (p_served)
    else $error("pending request not served");
  a_irq_enabled: assert property (p_irq_enabled)
    else $error("disabled interrupt set");
  a_combined: assert property (p_combined)
    else $error("combined interrupt wrong");
endmodule : adc_seq_chk

bind adc_conversion_sequencer adc_seq_chk u_chk (.core_clk(core_clk), .nrst(nrst),
  .pair_mode_select(pair_mode_select), .interrupt_source_select(interrupt_source_select),
  .mux_a_select(mux_a_select), .mux_b_select(mux_b_select), .sh_a_sample(sh_a_sample),
  .conv_start(conv_start), .conv_busy(conv_busy), .pending(pending), .irq_flag(irq_flag),
  .conversion_done_irq(conversion_done_irq));

// File: testbench/adc_front_model.sv
`timescale 1ns/1ps
// Analog front end and core: each hold unit follows its mux while sampling.
module adc_front_model (
  input  wire logic                  core_clk,     // Core clock.
  input  wire logic [1:0][2:0]       mux_a_select, // Mux A input.
  input  wire logic [1:0][2:0]       mux_b_select, // Mux B input.
  input  wire logic [1:0]            sh_a_sample,  // Hold A tracking.
  input  wire logic [1:0]            sh_b_sample,  // Hold B tracking.
  input  wire logic [1:0]            conv_start,   // Start pulse.
  input  wire logic [1:0]            conv_from_b,  // Convert hold B.
  input  wire logic [1:0][6:0][11:0] ain_a,        // Mux A levels.
  input  wire logic [1:0][3:0][11:0] ain_b,        // Mux B levels.
  output logic      [1:0][11:0]      conv_data     // Core data.
);
  logic [1:0][11:0] held_a_q = '0;
  logic [1:0][11:0] held_b_q = '0;
  logic [1:0][4:0]  cnt_q    = '1;
  // Track while sampling and keep the level after; the low reference sits at ground.
  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (sh_a_sample[i])
        held_a_q[i] <= ain_a[i][mux_a_select[i]];
      if (sh_b_sample[i])
        held_b_q[i] <= (mux_b_select[i] >= 3'h4) ? 12'h000 : ain_b[i][mux_b_select[i][1:0]];
      cnt_q[i] <= conv_start[i] ? 5'h01 : cnt_q[i] + {4'h0, cnt_q[i] != 5'h1F};
    end
  end
  // Data is inverted away from the capture edge, so a mistimed capture cannot match.
  always_comb
  begin
    for (int i = 0; i < 2; i++)
      conv_data[i] = (conv_from_b[i] ? held_b_q[i] : held_a_q[i]) ^ {12{cnt_q[i] <
        5'(adc_seq_pkg::CONV_CYCLES - 3) || cnt_q[i] > 5'(adc_seq_pkg::CONV_CYCLES + 2)}};
  end
endmodule : adc_front_model

// File: testbench/adc_conversion_sequencer_tb_top.sv
`timescale 1ns/1ps
// Drives triggers and settings, predicts results and flags, compares results after each round of eight triggers and at the end.
module adc_conversion_sequencer_tb_top;
  logic                   core_clk = 1'b0;
  logic                   nrst = 1'b0;
  logic [1:0][7:0]        ext_trigger = '0;
  logic [1:0][15:0][15:0] channel_conv_control = '0;
  logic [1:0][7:0]        pair_mode_select = '0;
  logic [1:0][15:0]       internal_trigger_select_lo = '0;
  logic [1:0][15:0]       internal_trigger_select_hi = '0;
  logic [1:0][4:0]        priority_control = '0;
  logic [1:0][7:0][4:0]   interrupt_source_select = '0;
  logic [1:0][7:0]        irq_ack = '0;
  logic [1:0][11:0]       conv_data;
  logic [1:0][2:0]        mux_a_select, mux_b_select;
  logic [1:0]             sh_a_sample, sh_b_sample, conv_start, conv_from_b, conv_busy;
  logic [1:0][15:0]       pending;
  logic [1:0][15:0][11:0] conv_result, exp_res = '0;
  logic [1:0][7:0]        irq_flag;
  logic [7:0]             conversion_done_irq;
  logic [1:0][6:0][11:0]  ain_a = '0;
  logic [1:0][3:0][11:0]  ain_b = '0;
  int                     mismatches = 0, checks = 0, cyc = 0;

  always #2.5 core_clk = ~core_clk;

  adc_conversion_sequencer u_dut (.core_clk, .nrst, .ext_trigger, .channel_conv_control,
    .pair_mode_select, .internal_trigger_select_lo, .internal_trigger_select_hi, .priority_control,
    .interrupt_source_select, .irq_ack, .conv_data, .mux_a_select, .mux_b_select, .sh_a_sample,
    .sh_b_sample, .conv_start, .conv_from_b, .conv_busy, .pending, .conv_result, .irq_flag,
    .conversion_done_irq);
  adc_front_model u_front (.core_clk, .mux_a_select, .mux_b_select, .sh_a_sample, .sh_b_sample,
    .conv_start, .conv_from_b, .ain_a, .ain_b, .conv_data);

  // Inputs always move one nanosecond after the rising edge.
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic check(input string what, input logic [383:0] seen, input logic [383:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  // Level a conversion reads; mux A has no sensor on the second converter.
  function automatic logic [11:0] lvl(input int cv, input logic b, input logic [2:0] s);
    if (b)
      return (s >= 3'h4) ? 12'h000 : ain_b[cv][s[1:0]];
    return ain_a[cv][(cv == 1 && s == 3'h6) ? 3'h0 : s];
  endfunction : lvl

  // Waits until no request is pending and both converters have stayed idle a while.
  task automatic wait_idle();
    int q;
    q = 0;
    for (int n = 0; n < 800 && q < 8; n++)
    begin
      tick(1);
      q = (pending === 32'h0 && conv_busy === 2'b00) ? q + 1 : 0;
    end
    check("idle", q >= 8, 1'b1);
  endtask : wait_idle

  // Pulses one trigger on both converters; channels t and t+8 use it and queue together.
  task automatic fire(input int t);
    logic [3:0] s;
    ext_trigger = {2{8'h01 << t}};
    tick(4);
    ext_trigger = '0;
    for (int cv = 0; cv < 2; cv++)
      for (int ch = t; ch < 16; ch += 8)
      begin
        s = channel_conv_control[cv][ch][3:0];
        if (!pair_mode_select[cv][ch / 2])
          exp_res[cv][ch] = lvl(cv, s[3], s[2:0]);
        else if (ch % 2 == 0)
        begin
          exp_res[cv][ch] = lvl(cv, 1'b0, s[2:0]);
          exp_res[cv][ch + 1] = lvl(cv, 1'b1, s[2:0]);
        end
      end
    wait_idle();
  endtask : fire

  // Ends a hung run.
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      test_done();
    end
  end

  // Singles, pairs and random mixes, then internal triggers and interrupts.
  initial
  begin
    void'($urandom(10));
    tick(5);
    check("reset_mux_b", mux_b_select, 6'h24);
    check("reset_result", conv_result, '0);
    tick(1);
    nrst = 1'b1;
    tick(3);
    for (int r = 0; r < 4; r++)
    begin
      for (int cv = 0; cv < 2; cv++)
      begin
        pair_mode_select[cv] = (r == 0) ? 8'h00 : ((r == 1) ? 8'hFF : 8'($urandom));
        priority_control[cv] = 5'($urandom_range(16));
        for (int ch = 0; ch < 16; ch++)
        begin
          channel_conv_control[cv][ch] = {9'($urandom_range(3)), 3'(ch % 8), 1'($urandom),
                                          3'($urandom_range(6))};
          if (ch < 7)
            ain_a[cv][ch] = 12'($urandom);
          if (ch < 4)
            ain_b[cv][ch] = 12'($urandom);
        end
      end
      tick(1);
      for (int t = 0; t < 8; t++)
        fire(t);
      check("conv_result", conv_result, exp_res);
    end
    pair_mode_select = '0;
    internal_trigger_select_lo = {2{16'h8000}};
    internal_trigger_select_hi = {2{16'h4000}};
    interrupt_source_select = {2{30'h0, 5'h1B, 5'h13}};
    for (int cv = 0; cv < 2; cv++)
      for (int ch = 14; ch < 16; ch++)
        exp_res[cv][ch] = lvl(cv, channel_conv_control[cv][ch][3], channel_conv_control[cv][ch][2:0]);
    tick(1);
    fire(3);
    check("conv_result", conv_result, exp_res);
    check("irq_flag", irq_flag, 16'h0303);
    check("combined", conversion_done_irq, 8'h03);
    irq_ack = 16'h0001;
    tick(1);
    irq_ack = '0;
    tick(2);
    check("irq_flag", irq_flag, 16'h0302);
    check("combined", conversion_done_irq, 8'h02);
    test_done();
  end
endmodule : adc_conversion_sequencer_tb_top
